// ### rtl/lfc_pkg.sv
// Shared constants and types for the lifetime counter block.
// Assumes the register port carries 8-bit byte addresses inside the
// 256-byte window and 16-bit data with the even byte in bits 15:8.
package lfc_pkg;

    // Width of the lifetime count.
    localparam int COUNT_WIDTH = 32;

    // Byte offsets of the registers inside the window.
    localparam logic [7:0] ADDR_ENABLE_MASKS = 8'h38;
    localparam logic [7:0] ADDR_CONTROL      = 8'h39;
    localparam logic [7:0] ADDR_STATUS       = 8'h3a;
    localparam logic [7:0] ADDR_RESERVED     = 8'h3b;
    localparam logic [7:0] ADDR_COUNT_UPPER  = 8'h3c;
    localparam logic [7:0] ADDR_COUNT_LOWER  = 8'h3e;

    // Bit positions inside the mask, control and status bytes.
    localparam int BIT_COUNT_ENABLE_MASK = 0;
    localparam int BIT_IRQ_ENABLE_MASK   = 7;
    localparam int BIT_COUNT_ENABLE      = 0;
    localparam int BIT_IRQ_ENABLE        = 7;
    localparam int BIT_OVERFLOW_FLAG     = 7;

    // Reset values of the stored state.
    localparam logic [31:0] RESET_COUNT = 32'h0000_0000;
    localparam logic        RESET_BIT   = 1'h0;
    localparam logic [15:0] RESET_WORD  = 16'h0000;
    localparam logic [7:0]  ZERO_BYTE   = 8'h00;

    // Freeze sequencer: which count word must still be read.
    typedef enum logic [1:0] {
        LFC_RUN        = 2'b00,
        LFC_WAIT_LOWER = 2'b01,
        LFC_WAIT_UPPER = 2'b10
    } lfc_freeze_type;

endpackage : lfc_pkg

// ### rtl/lfc_tick.sv
// Count strobe generator for the lifetime counter.
// Assumes the always-on slow clock arrives as a level already
// synchronous to the reference clock and far slower than it.
`timescale 1ns/10ps
module lfc_tick (
    input  wire logic clk,       // Reference clock.
    input  wire logic nrst,      // Asynchronous reset, active low.
    input  wire logic slow_clk,  // Always-on slow clock level.
    output logic      tick       // One-cycle strobe per slow rising edge.
);

    // All state of this module in one record.
    typedef struct packed {
        logic prev;   // Slow clock level seen one cycle earlier.
        logic strobe; // Registered rising-edge strobe.
    } lfc_tick_type;

    lfc_tick_type st;      // Current state.
    lfc_tick_type next_st; // Next state.

    // A rising edge of the slow clock yields one strobe. Since the slow
    // clock runs freely beside the enable, the first period after an
    // enable is only the remainder of the current slow period.
    always_comb begin
        next_st        = st;
        next_st.prev   = slow_clk;
        next_st.strobe = slow_clk && !st.prev;
    end

    // Register the state.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign tick = st.strobe;

    // A strobe never lasts two cycles.
    a_tick_single: assert property (
        @(posedge clk) disable iff (!nrst)
        tick |=> !tick) else $error("count strobe lasted two cycles");

endmodule : lfc_tick

// ### rtl/lfc_top.sv
// Lifetime counter: a 32-bit count driven by the always-on slow clock,
// with write-masked enables, a sticky overflow flag, an interrupt level
// and a wake-up strobe for the power controller.
// Assumes the die link logic outside turns each bus transaction into one
// single-cycle strobe on the register port below.
//
// Notes on behaviour
// - Counts on slow clock in every power mode.
// - Overflow sends wake-up pulse to power controller.
// - Count enable written only with its mask.
// - Irq enable written only with its mask.
// - Count enable bit runs or holds counter.
// - Irq enable gates overflow interrupt request.
// - First period after enable may be short.
// - Overflow flag sticky until software clears it.
// - Writing one clears flag; zero leaves it.
// - Count readable as upper and lower words.
// - Reading one word freezes until other read.
`timescale 1ns/10ps
module lfc_top (
    input  wire logic        REF_CLK,   // Reference clock, 125 MHz.
    input  wire logic        NRST,      // Asynchronous reset, active low.
    input  wire logic        SLOW_CLK,  // Always-on slow clock level.
    input  wire logic [7:0]  REG_ADDR,  // Byte address inside the window.
    input  wire logic        REG_WR,    // Write strobe, one cycle.
    input  wire logic        REG_RD,    // Read strobe, one cycle.
    input  wire logic        REG_WORD,  // 1: 16-bit access, 0: byte.
    input  wire logic [15:0] REG_WDATA, // Write data.
    output logic      [15:0] REG_RDATA, // Read data, one cycle later.
    output logic             IRQ,       // Overflow interrupt request.
    output logic             WAKEUP     // Wake-up strobe on overflow.
);

    // All state of the block in one record.
    typedef struct packed {
        lfc_pkg::lfc_freeze_type state; // Freeze sequencer.
        logic [31:0] count;             // Lifetime count.
        logic        count_enable;      // Counting allowed.
        logic        irq_enable;        // Interrupt allowed.
        logic        overflow_flag;     // Sticky overflow.
        logic        wakeup;            // Wake-up strobe.
        logic [15:0] rdata;             // Registered read data.
    } lfc_regs_type;

    lfc_regs_type st;      // Current state.
    lfc_regs_type next_st; // Next state.
    logic         tick;    // One strobe per slow clock period.

    // True when the access covers the given byte address.
    function automatic logic byte_hit(input logic [7:0] addr,
                                      input logic       word,
                                      input logic [7:0] target);
        byte_hit = word ? (addr[7:1] == target[7:1]) : (addr == target);
    endfunction : byte_hit

    // Write data belonging to the given byte address.
    function automatic logic [7:0] byte_data(input logic [15:0] wdata,
                                             input logic        word,
                                             input logic [7:0]  target);
        if (word && !target[0]) begin
            byte_data = wdata[15:8];
        end else begin
            byte_data = wdata[7:0];
        end
    endfunction : byte_data

    // Readback of one byte address; unmapped addresses read as zero.
    function automatic logic [7:0] byte_read(input lfc_regs_type s,
                                             input logic [7:0]   addr);
        logic [7:0] v;
        v = lfc_pkg::ZERO_BYTE;
        if (addr == lfc_pkg::ADDR_CONTROL) begin
            v[lfc_pkg::BIT_COUNT_ENABLE] = s.count_enable;
            v[lfc_pkg::BIT_IRQ_ENABLE]   = s.irq_enable;
        end else if (addr == lfc_pkg::ADDR_STATUS) begin
            v[lfc_pkg::BIT_OVERFLOW_FLAG] = s.overflow_flag;
        end else if (addr[7:1] == lfc_pkg::ADDR_COUNT_UPPER[7:1]) begin
            v = addr[0] ? s.count[23:16] : s.count[31:24];
        end else if (addr[7:1] == lfc_pkg::ADDR_COUNT_LOWER[7:1]) begin
            v = addr[0] ? s.count[7:0] : s.count[15:8];
        end
        byte_read = v;
    endfunction : byte_read

    // Decoded accesses, shared by the next-state logic and the checks.
    logic       wr_masks;      // Write reaches the mask byte.
    logic       wr_control;    // Write reaches the control byte.
    logic       wr_status;     // Write reaches the status byte.
    logic [7:0] mask_byte;     // Mask bits of this access.
    logic [7:0] control_byte;  // Control bits of this access.
    logic [7:0] status_byte;   // Status bits of this access.
    logic       wr_upper;      // Word write of the upper count.
    logic       wr_lower;      // Word write of the lower count.
    logic       rd_upper;      // Word read of the upper count.
    logic       rd_lower;      // Word read of the lower count.
    logic       step;          // Counter advances this cycle.
    logic       wrap;          // Counter passes all ones this cycle.
    logic       clear_flag;    // Software clears the overflow flag.
    logic       count_write;   // Masked write of the count enable.
    logic       irq_write;     // Masked write of the irq enable.

    // Access decode. Count words take part only in word accesses, so a
    // byte access never writes them or moves the freeze sequencer.
    always_comb begin
        wr_masks   = REG_WR && byte_hit(REG_ADDR, REG_WORD,
                                        lfc_pkg::ADDR_ENABLE_MASKS);
        wr_control = REG_WR && byte_hit(REG_ADDR, REG_WORD,
                                        lfc_pkg::ADDR_CONTROL);
        wr_status  = REG_WR && byte_hit(REG_ADDR, REG_WORD,
                                        lfc_pkg::ADDR_STATUS);
        // A mask only counts when written in this same access.
        mask_byte    = wr_masks ? byte_data(REG_WDATA, REG_WORD,
                       lfc_pkg::ADDR_ENABLE_MASKS) : lfc_pkg::ZERO_BYTE;
        control_byte = byte_data(REG_WDATA, REG_WORD, lfc_pkg::ADDR_CONTROL);
        status_byte  = byte_data(REG_WDATA, REG_WORD, lfc_pkg::ADDR_STATUS);
        wr_upper = REG_WR && REG_WORD
                   && REG_ADDR == lfc_pkg::ADDR_COUNT_UPPER;
        wr_lower = REG_WR && REG_WORD
                   && REG_ADDR == lfc_pkg::ADDR_COUNT_LOWER;
        rd_upper = REG_RD && REG_WORD
                   && REG_ADDR == lfc_pkg::ADDR_COUNT_UPPER;
        rd_lower = REG_RD && REG_WORD
                   && REG_ADDR == lfc_pkg::ADDR_COUNT_LOWER;
        // Power mode is not an input: only the enable and a pending
        // word read can hold the counter.
        step = tick && st.count_enable
               && st.state == lfc_pkg::LFC_RUN;
        wrap = step && (&st.count);
        clear_flag = wr_status
                     && status_byte[lfc_pkg::BIT_OVERFLOW_FLAG];
        // An enable moves only when its own mask rides in this access.
        count_write = wr_control
                      && mask_byte[lfc_pkg::BIT_COUNT_ENABLE_MASK];
        irq_write   = wr_control
                      && mask_byte[lfc_pkg::BIT_IRQ_ENABLE_MASK];
    end

    // Next-state logic for every register of the block.
    always_comb begin
        next_st        = st;
        next_st.wakeup = wrap;

        // Enable bits change only where their mask is written as one.
        if (count_write) begin
            next_st.count_enable =
                control_byte[lfc_pkg::BIT_COUNT_ENABLE];
        end
        if (irq_write) begin
            next_st.irq_enable =
                control_byte[lfc_pkg::BIT_IRQ_ENABLE];
        end

        // The counter steps and wraps; a software word write wins over
        // a step in the same cycle, since software asked for that value.
        if (step) begin
            next_st.count = st.count + 32'h0000_0001;
        end
        if (wr_upper) begin
            next_st.count[31:16] = REG_WDATA;
        end
        if (wr_lower) begin
            next_st.count[15:0] = REG_WDATA;
        end

        // The flag is sticky; an overflow in the clearing cycle wins.
        if (clear_flag) begin
            next_st.overflow_flag = 1'b0;
        end
        if (wrap) begin
            next_st.overflow_flag = 1'b1;
        end

        // Freeze sequencer: the first word read stops counting until
        // the other word is read, so both halves come from one value unless a step lands in the cycle of the first read.
        case (st.state)
            lfc_pkg::LFC_RUN: begin
                if (rd_upper) begin
                    next_st.state = lfc_pkg::LFC_WAIT_LOWER;
                end else if (rd_lower) begin
                    next_st.state = lfc_pkg::LFC_WAIT_UPPER;
                end
            end
            lfc_pkg::LFC_WAIT_LOWER: begin
                if (rd_lower) begin
                    next_st.state = lfc_pkg::LFC_RUN;
                end
            end
            lfc_pkg::LFC_WAIT_UPPER: begin
                if (rd_upper) begin
                    next_st.state = lfc_pkg::LFC_RUN;
                end
            end
            default: begin
                next_st.state = lfc_pkg::LFC_RUN;
            end
        endcase

        // Read data: even byte high on a word access, low on a byte.
        if (REG_RD && REG_WORD) begin
            next_st.rdata = {byte_read(st, {REG_ADDR[7:1], 1'b0}),
                             byte_read(st, {REG_ADDR[7:1], 1'b1})};
        end else if (REG_RD) begin
            next_st.rdata = {lfc_pkg::ZERO_BYTE, byte_read(st, REG_ADDR)};
        end
    end

    // Register the state; every field takes a constant under reset.
    always_ff @(posedge REF_CLK or negedge NRST) begin
        if (!NRST) begin
            st.state         <= lfc_pkg::LFC_RUN;
            st.count         <= lfc_pkg::RESET_COUNT;
            st.count_enable  <= lfc_pkg::RESET_BIT;
            st.irq_enable    <= lfc_pkg::RESET_BIT;
            st.overflow_flag <= lfc_pkg::RESET_BIT;
            st.wakeup        <= lfc_pkg::RESET_BIT;
            st.rdata         <= lfc_pkg::RESET_WORD;
        end else begin
            st <= next_st;
        end
    end

    // Slow clock strobe.
    lfc_tick u_lfc_tick (
        .clk      (REF_CLK),
        .nrst     (NRST),
        .slow_clk (SLOW_CLK),
        .tick     (tick)
    );

    // Outputs: interrupt is a level from two stored bits.
    assign IRQ       = st.overflow_flag && st.irq_enable;
    assign WAKEUP    = st.wakeup;
    assign REG_RDATA = st.rdata;

    // Enabled running counter advances by exactly one per strobe.
    a_count_step: assert property (
        @(posedge REF_CLK) disable iff (!NRST)
        (tick && st.count_enable && st.state == lfc_pkg::LFC_RUN
         && !wr_upper && !wr_lower)
        |=> st.count == $past(st.count) + 32'h0000_0001)
        else $error("enabled counter did not step");

    // A disabled counter keeps its value.
    a_count_hold: assert property (
        @(posedge REF_CLK) disable iff (!NRST)
        (!st.count_enable && !wr_upper && !wr_lower) |=> $stable(st.count))
        else $error("disabled counter changed");

    // Overflow wraps to zero and sets the flag; wake-up is low one cycle after that.
    a_wrap_zero: assert property (
        @(posedge REF_CLK) disable iff (!NRST)
        (step && st.count == 32'hffff_ffff && !wr_upper && !wr_lower)
        |=> st.count == 32'h0000_0000 && st.overflow_flag ##1 WAKEUP == 0)
        else $error("overflow did not wrap and flag");

    // Wake-up strobe is exactly one cycle per overflow.
    a_wake_pulse: assert property (
        @(posedge REF_CLK) disable iff (!NRST)
        wrap |=> WAKEUP ##1 !WAKEUP)
        else $error("wake-up strobe wrong");

    // Flag stays set unless cleared by a written one.
    a_flag_sticky: assert property (
        @(posedge REF_CLK) disable iff (!NRST)
        (st.overflow_flag && !clear_flag) |=> st.overflow_flag)
        else $error("overflow flag dropped by itself");

    // A written one clears the flag when no overflow collides.
    a_flag_clear: assert property (
        @(posedge REF_CLK) disable iff (!NRST)
        (clear_flag && !wrap) |=> !st.overflow_flag)
        else $error("write one did not clear flag");

    // Control write without the count mask leaves count enable alone.
    a_mask_count: assert property (
        @(posedge REF_CLK) disable iff (!NRST)
        (!(wr_masks && REG_WDATA[8 + lfc_pkg::BIT_COUNT_ENABLE_MASK]
           && REG_WORD)) |=> $stable(st.count_enable))
        else $error("count enable changed without mask");

    // Control write without the irq mask leaves irq enable alone.
    a_mask_irq: assert property (
        @(posedge REF_CLK) disable iff (!NRST)
        (!(wr_masks && REG_WDATA[8 + lfc_pkg::BIT_IRQ_ENABLE_MASK]
           && REG_WORD)) |=> $stable(st.irq_enable))
        else $error("irq enable changed without mask");

    // After an upper-word read the sequencer waits for the lower read and the next cycle takes no step.
    a_read_freeze: assert property (
        @(posedge REF_CLK) disable iff (!NRST)
        (st.state == lfc_pkg::LFC_RUN && rd_upper)
        |=> (st.state == lfc_pkg::LFC_WAIT_LOWER && !step))
        else $error("upper read did not freeze count");

    // Interrupt follows flag and enable in the same cycle.
    a_irq_level: assert property (
        @(posedge REF_CLK) disable iff (!NRST)
        $rose(IRQ) |-> st.overflow_flag && st.irq_enable)
        else $error("interrupt without flag and enable");

    // A masked count enable write stores the bit taken from the bus itself.
    a_count_write: assert property (
        @(posedge REF_CLK) disable iff (!NRST)
        count_write |=> st.count_enable
                        == $past(REG_WDATA[lfc_pkg::BIT_COUNT_ENABLE]))
        else $error("masked count enable write not stored");

    // The interrupt only rises after an overflow or an enable write.
    a_irq_cause: assert property (
        @(posedge REF_CLK) disable iff (!NRST)
        $rose(IRQ) |-> $past(wrap) || $past(irq_write))
        else $error("interrupt rose without a cause");

endmodule : lfc_top

// ### sim/lfc_host_model.sv
// Bus master model standing in for the microcontroller on the die link.
// Assumes the counter takes one strobe per access on the rising edge.
`timescale 1ns/10ps
module lfc_host_model (
    input  wire logic        clk,      // Reference clock.
    input  wire logic [15:0] rdata,    // Read data from the counter.
    output logic             slow_clk, // Always-on slow clock level.
    output logic [7:0]       addr,     // Byte address in the window.
    output logic             wr,       // Write strobe.
    output logic             rd,       // Read strobe.
    output logic             word,     // One for a 16-bit access.
    output logic [15:0]      wdata     // Write data.
);
    // Global base of blocking accesses; the low byte is the offset.
    localparam logic [15:0] BLOCKING_BASE = 16'h0200;

    // Idle levels from time zero, so nothing reaches the block unknown.
    initial begin
        slow_clk = 1'b0;
        addr     = 8'h00;
        wr       = 1'b0;
        rd       = 1'b0;
        word     = 1'b0;
        wdata    = 16'h0000;
    end

    // One access: command, address and data held for one strobe cycle.
    task automatic issue(input logic [7:0] offs, input logic is_wr,
                         input logic is_word, input logic [15:0] data);
        logic [15:0] glob;
        glob = BLOCKING_BASE + {8'h00, offs};
        @(posedge clk);
        addr  <= glob[7:0];
        wr    <= is_wr;
        rd    <= !is_wr;
        word  <= is_word;
        wdata <= data;
        @(posedge clk);
        wr    <= 1'b0;
        rd    <= 1'b0;
        // A released bus shows inverse address and data; only word keeps its old level.
        addr  <= ~glob[7:0];
        wdata <= ~data;
    endtask : issue

    // Read data is registered, so it is taken just after the strobe edge.
    task automatic read_reg(input logic [7:0] offs, input logic is_word,
                            output logic [15:0] value);
        issue(offs, 1'b0, is_word, 16'h0000);
        #1;
        value = rdata;
    endtask : read_reg

    // The count is only written as words and with counting halted.
    task automatic write_count(input logic [31:0] value);
        issue(8'h38, 1'b1, 1'b1, 16'h0100);
        issue(8'h3c, 1'b1, 1'b1, value[31:16]);
        issue(8'h3e, 1'b1, 1'b1, value[15:0]);
    endtask : write_count

    // Slow clock pulses, each phase several reference cycles long.
    task automatic slow_pulses(input int n);
        for (int i = 0; i < n; i++) begin
            repeat (3) @(posedge clk);
            slow_clk <= ~slow_clk;
            repeat (3) @(posedge clk);
            slow_clk <= ~slow_clk;
        end
        // Let the last step land before anyone looks.
        repeat (4) @(posedge clk);
    endtask : slow_pulses
endmodule : lfc_host_model

// ### sim/test_lfc_top.sv
// Self-checking bench for the lifetime counter.
// Assumes the host model drives every register access and the slow clock.
`timescale 1ns/10ps
module test_lfc_top;
    logic        REF_CLK;            // Reference clock.
    logic        NRST;               // Reset, active low.
    logic        SLOW_CLK;           // Slow clock from the model.
    logic [7:0]  REG_ADDR;           // Access address.
    logic        REG_WR;             // Write strobe.
    logic        REG_RD;             // Read strobe.
    logic        REG_WORD;           // Word access select.
    logic [15:0] REG_WDATA;          // Write data.
    logic [15:0] REG_RDATA;          // Read data.
    logic        IRQ;                // Interrupt level.
    logic        WAKEUP;             // Wake-up strobe.
    int          num_errors = 0;     // Mismatches seen.
    int          compares   = 0;     // Comparisons made.
    int          wake_count = 0;     // Wake-up strobes seen.
    int          cycles     = 0;     // Clock cycles run.

    lfc_top u_lfc_top (.REF_CLK(REF_CLK), .NRST(NRST), .SLOW_CLK(SLOW_CLK),
        .REG_ADDR(REG_ADDR), .REG_WR(REG_WR), .REG_RD(REG_RD),
        .REG_WORD(REG_WORD), .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA),
        .IRQ(IRQ), .WAKEUP(WAKEUP));

    lfc_host_model u_lfc_host_model (.clk(REF_CLK), .rdata(REG_RDATA),
        .slow_clk(SLOW_CLK), .addr(REG_ADDR), .wr(REG_WR), .rd(REG_RD),
        .word(REG_WORD), .wdata(REG_WDATA));

    // The 125 MHz reference clock.
    initial begin
        REF_CLK = 1'b0;
        forever #4 REF_CLK = ~REF_CLK;
    end

    // Wake-up is a one-cycle strobe, so it is counted on every edge.
    // The run needs well under a thousand cycles; the ceiling cuts a hang.
    always @(posedge REF_CLK) begin
        cycles++;
        if (WAKEUP === 1'b1) begin
            wake_count++;
        end
        if (cycles == 5000) begin
            num_errors++;
            wrap_up();
        end
    end

    task automatic check_word(input string what, input logic [15:0] exp,
                              input logic [15:0] got);
        compares++;
        if (got !== exp) begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask : check_word

    task automatic check_bit(input string what, input logic exp,
                             input logic got);
        compares++;
        if (got !== exp) begin
            num_errors++;
            $display("ERROR %s expected %b seen %b", what, exp, got);
        end
    endtask : check_bit

    // Reads a register through the model and compares it.
    task automatic expect_reg(input string what, input logic [7:0] offs,
                              input logic word, input logic [15:0] exp);
        logic [15:0] val;
        u_lfc_host_model.read_reg(offs, word, val);
        check_word(what, exp, val);
    endtask : expect_reg

    // A write, then one more edge so levels derived from state settle.
    task automatic put(input logic [7:0] offs, input logic word,
                       input logic [15:0] data);
        u_lfc_host_model.issue(offs, 1'b1, word, data);
        @(posedge REF_CLK);
        #1;
    endtask : put

    task automatic wrap_up();
        $display("errors %0d compares %0d", num_errors, compares);
        if (num_errors == 0 && compares > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : wrap_up

    // Main sequence: reset state, masked enables, counting, overflow.
    initial begin
        NRST = 1'b0;
        repeat (4) @(posedge REF_CLK);
        NRST <= 1'b1;
        expect_reg("control", 8'h39, 1'b0, 16'h0000);
        expect_reg("status", 8'h3a, 1'b0, 16'h0000);
        expect_reg("reserved", 8'h3b, 1'b0, 16'h0000);
        expect_reg("masks", 8'h38, 1'b0, 16'h0000);
        // Enable values without their masks must be ignored.
        put(8'h38, 1'b1, 16'h0081);
        put(8'h39, 1'b0, 16'h0081);
        expect_reg("no mask", 8'h39, 1'b0, 16'h0000);
        put(8'h38, 1'b1, 16'h8080);
        expect_reg("irq mask", 8'h39, 1'b0, 16'h0080);
        put(8'h38, 1'b1, 16'h0101);
        expect_reg("count mask", 8'h39, 1'b0, 16'h0081);
        put(8'h38, 1'b1, 16'h0100);
        expect_reg("count off", 8'h39, 1'b0, 16'h0080);
        // Counting halts while disabled and runs once enabled.
        u_lfc_host_model.write_count(32'h1234_5678);
        u_lfc_host_model.slow_pulses(3);
        expect_reg("held up", 8'h3c, 1'b1, 16'h1234);
        expect_reg("held low", 8'h3e, 1'b1, 16'h5678);
        put(8'h38, 1'b1, 16'h0101);
        u_lfc_host_model.slow_pulses(5);
        expect_reg("run up", 8'h3c, 1'b1, 16'h1234);
        // The upper read froze the count; these steps must be lost.
        u_lfc_host_model.slow_pulses(3);
        expect_reg("frozen low", 8'h3e, 1'b1, 16'h567d);
        u_lfc_host_model.slow_pulses(2);
        put(8'h38, 1'b1, 16'h0100);
        expect_reg("resumed low", 8'h3e, 1'b1, 16'h567f);
        expect_reg("resumed up", 8'h3c, 1'b1, 16'h1234);
        // Overflow with the interrupt enabled.
        u_lfc_host_model.write_count(32'hffff_fffe);
        put(8'h38, 1'b1, 16'h8181);
        u_lfc_host_model.slow_pulses(1);
        check_bit("irq early", 1'b0, IRQ);
        check_word("no wakeup", 16'h0000, 16'(wake_count));
        u_lfc_host_model.slow_pulses(1);
        check_bit("irq", 1'b1, IRQ);
        check_word("wakeups", 16'h0001, 16'(wake_count));
        expect_reg("flag", 8'h3a, 1'b0, 16'h0080);
        u_lfc_host_model.slow_pulses(1);
        put(8'h38, 1'b1, 16'h0100);
        expect_reg("wrap up", 8'h3c, 1'b1, 16'h0000);
        expect_reg("wrap low", 8'h3e, 1'b1, 16'h0001);
        put(8'h3a, 1'b0, 16'h0000);
        expect_reg("kept", 8'h3a, 1'b0, 16'h0080);
        put(8'h38, 1'b1, 16'h8000);
        check_bit("irq masked", 1'b0, IRQ);
        put(8'h38, 1'b1, 16'h8080);
        check_bit("irq again", 1'b1, IRQ);
        put(8'h3a, 1'b0, 16'h0080);
        expect_reg("cleared", 8'h3a, 1'b0, 16'h0000);
        check_bit("irq cleared", 1'b0, IRQ);
        // Byte accesses to the count neither write it nor freeze it.
        put(8'h3f, 1'b0, 16'h00ff);
        expect_reg("count byte", 8'h3f, 1'b0, 16'h0001);
        put(8'h38, 1'b1, 16'h0101);
        u_lfc_host_model.slow_pulses(1);
        put(8'h38, 1'b1, 16'h0100);
        expect_reg("no freeze low", 8'h3e, 1'b1, 16'h0002);
        expect_reg("no freeze up", 8'h3c, 1'b1, 16'h0000);
        // A reset in mid-run clears the count and both enables.
        NRST <= 1'b0;
        repeat (2) @(posedge REF_CLK);
        NRST <= 1'b1;
        expect_reg("reset control", 8'h39, 1'b0, 16'h0000);
        expect_reg("reset low", 8'h3e, 1'b1, 16'h0000);
        expect_reg("reset up", 8'h3c, 1'b1, 16'h0000);
        wrap_up();
    end
endmodule : test_lfc_top
